// ### rtl/vbb_map.svh
`ifndef VBB_MAP_SVH
`define VBB_MAP_SVH

// ****************************************************************
// widths of the datapath
// ****************************************************************
`define VEC_W       128
`define PC_W        32
`define OFF_W       16
`define IMM_W       8
`define BIDX_W      6
`define NUM_FMT     4

// ****************************************************************
// branch address arithmetic
// ****************************************************************
`define WORD_SHIFT  2
`define INSN_BYTES  32'h0000_0004
`define PC_RESET    32'h0000_0000

`endif

// ### rtl/vbb_pkg.sv
package vbb_pkg;

  typedef enum logic [1:0] {
    FMT_BYTE,
    FMT_HALF,
    FMT_WORD,
    FMT_DOUBLE
  } data_format_t;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_BRANCH_IF_NONZERO_ELEM,
    OP_BRANCH_IF_NONZERO_VEC,
    OP_BRANCH_IF_ZERO_ELEM,
    OP_BRANCH_IF_ZERO_VEC,
    OP_VECTOR_BIT_SELECT,
    OP_IMMEDIATE_BIT_SELECT,
    OP_VECTOR_BIT_FORCE_ONE,
    OP_IMMEDIATE_BIT_FORCE_ONE,
    OP_VECTOR_EQUAL_COMPARE
  } op_t;

endpackage

// ### rtl/element_lane_unit.sv
`timescale 1ns/1ps
`include "vbb_map.svh"

// per-element bit force and equality compare for all four formats
module element_lane_unit
  import vbb_pkg::*;
(
  input  wire data_format_t        data_format,
  input  wire logic [`VEC_W-1:0]   source_vector,
  input  wire logic [`VEC_W-1:0]   second_vector,
  input  wire logic [`BIDX_W-1:0]  bit_index_imm,
  output logic      [`VEC_W-1:0]   equal_res,
  output logic      [`VEC_W-1:0]   force_reg_res,
  output logic      [`VEC_W-1:0]   force_imm_res
);

  logic [`NUM_FMT-1:0][`VEC_W-1:0] eq_f;
  logic [`NUM_FMT-1:0][`VEC_W-1:0] setr_f;
  logic [`NUM_FMT-1:0][`VEC_W-1:0] seti_f;

  function automatic logic [`VEC_W-1:0] pick_fmt(
    input logic [`NUM_FMT-1:0][`VEC_W-1:0] arr,
    input data_format_t                     fmt
  );
    pick_fmt = arr[fmt];
  endfunction

  // ****************************************************************
  // one generate branch per format, one lane per element
  // ****************************************************************
  genvar f, e;
  generate
    for (f = 0; f < `NUM_FMT; f++) begin : g_fmt
      localparam int EW = 8 << f;
      localparam int LW = 3 + f;
      localparam int NE = `VEC_W / EW;
      for (e = 0; e < NE; e++) begin : g_elem
        wire logic [EW-1:0] a_el = source_vector[e*EW +: EW];
        wire logic [EW-1:0] b_el = second_vector[e*EW +: EW];
        // position modulo element width: low bits only, no trap case
        wire logic [LW-1:0] pos_r = b_el[LW-1:0];
        wire logic [LW-1:0] pos_i = bit_index_imm[LW-1:0];
        assign eq_f[f][e*EW +: EW]   = {EW{a_el == b_el}};
        assign setr_f[f][e*EW +: EW] = a_el | (EW'(1) << pos_r);
        assign seti_f[f][e*EW +: EW] = a_el | (EW'(1) << pos_i);
      end
    end
  endgenerate

  assign equal_res     = pick_fmt(eq_f, data_format);
  assign force_reg_res = pick_fmt(setr_f, data_format);
  assign force_imm_res = pick_fmt(seti_f, data_format);

endmodule

// ### rtl/branch_cond_unit.sv
`timescale 1ns/1ps
`include "vbb_map.svh"

// zero tests on the vector under test, per element and whole vector
module branch_cond_unit
  import vbb_pkg::*;
(
  input  wire data_format_t       data_format,
  input  wire logic [`VEC_W-1:0]  test_vector,
  output logic                    any_elem_zero,
  output logic                    all_elem_nonzero,
  output logic                    vec_zero,
  output logic                    vec_nonzero
);

  logic [`NUM_FMT-1:0] zero_f;

  genvar f, e;
  generate
    for (f = 0; f < `NUM_FMT; f++) begin : g_fmt
      localparam int EW = 8 << f;
      localparam int NE = `VEC_W / EW;
      logic [NE-1:0] el_zero;
      for (e = 0; e < NE; e++) begin : g_elem
        assign el_zero[e] = ~|test_vector[e*EW +: EW];
      end
      assign zero_f[f] = |el_zero;
    end
  endgenerate

  assign any_elem_zero    = zero_f[data_format];
  assign all_elem_nonzero = ~zero_f[data_format];
  assign vec_nonzero      = |test_vector;
  assign vec_zero         = ~|test_vector;

endmodule

// ### rtl/vector_bit_branch_compare.sv
// Overview of operation
// - every vector branch lets its delay-slot instruction run, taken or not
// - target is delay-slot address plus offset words, shifted two, sign-extended
// - element non-zero branch taken only if every element is non-zero
// - whole-vector non-zero branch taken if any bit is set
// - element zero branch taken if some element equals zero
// - whole-vector zero branch taken only if all bits are zero
// - register select: destination bit picks first (0) or second (1) source
// - immediate select: destination bit picks source (0) or immediate bit (1)
// - register force-one sets bit at second-source element modulo width
// - immediate force-one sets the immediate-indexed bit in every element
// - equality compare writes all ones where equal, zeros otherwise
// - element ops cover width over element size lanes: 8,16,32,64 bits
// - force-one and compare never raise a data-dependent exception
`timescale 1ns/1ps
`include "vbb_map.svh"

module vector_bit_branch_compare
  import vbb_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                issue_valid,
  input  wire op_t                 op,
  input  wire data_format_t        data_format,
  input  wire logic [`VEC_W-1:0]   dest_vector,
  input  wire logic [`VEC_W-1:0]   source_vector,
  input  wire logic [`VEC_W-1:0]   second_vector,
  input  wire logic [`IMM_W-1:0]   byte_immediate,
  input  wire logic [`BIDX_W-1:0]  bit_index_imm,
  input  wire logic [`OFF_W-1:0]   branch_offset_imm,
  input  wire logic [`PC_W-1:0]    delay_slot_pc,
  output logic                     wr_en_ff,
  output logic      [`VEC_W-1:0]   result_ff,
  output logic                     branch_valid_ff,
  output logic                     branch_taken_ff,
  output logic      [`PC_W-1:0]    branch_target_ff,
  output logic      [`PC_W-1:0]    next_pc_ff,
  output logic                     delay_slot_run_ff,
  output logic                     data_exc_ff
);

  // ****************************************************************
  // op decoding
  // ****************************************************************
  function automatic logic is_branch_op(input op_t o);
    is_branch_op = (o == OP_BRANCH_IF_NONZERO_ELEM) ||
                   (o == OP_BRANCH_IF_NONZERO_VEC)  ||
                   (o == OP_BRANCH_IF_ZERO_ELEM)    ||
                   (o == OP_BRANCH_IF_ZERO_VEC);
  endfunction

  function automatic logic is_write_op(input op_t o);
    is_write_op = (o == OP_VECTOR_BIT_SELECT)       ||
                  (o == OP_IMMEDIATE_BIT_SELECT)    ||
                  (o == OP_VECTOR_BIT_FORCE_ONE)    ||
                  (o == OP_IMMEDIATE_BIT_FORCE_ONE) ||
                  (o == OP_VECTOR_EQUAL_COMPARE);
  endfunction

  wire logic is_branch = issue_valid && is_branch_op(op);
  wire logic is_write  = issue_valid && is_write_op(op);

  // ****************************************************************
  // element-wise datapath
  // ****************************************************************
  logic [`VEC_W-1:0] equal_res;
  logic [`VEC_W-1:0] force_reg_res;
  logic [`VEC_W-1:0] force_imm_res;

  element_lane_unit u_lanes (
    .data_format   (data_format),
    .source_vector (source_vector),
    .second_vector (second_vector),
    .bit_index_imm (bit_index_imm),
    .equal_res     (equal_res),
    .force_reg_res (force_reg_res),
    .force_imm_res (force_imm_res)
  );

  // destination acts as the per-bit selector
  wire logic [`VEC_W-1:0] sel_reg_res =
    (source_vector & ~dest_vector) | (second_vector & dest_vector);
  wire logic [`VEC_W-1:0] imm_rep = {(`VEC_W / `IMM_W){byte_immediate}};
  wire logic [`VEC_W-1:0] sel_imm_res =
    (source_vector & ~dest_vector) | (imm_rep & dest_vector);

  wire logic [`VEC_W-1:0] op_result =
    (op == OP_VECTOR_BIT_SELECT)       ? sel_reg_res   :
    (op == OP_IMMEDIATE_BIT_SELECT)    ? sel_imm_res   :
    (op == OP_VECTOR_BIT_FORCE_ONE)    ? force_reg_res :
    (op == OP_IMMEDIATE_BIT_FORCE_ONE) ? force_imm_res :
    equal_res;

  // ****************************************************************
  // branch condition and target
  // ****************************************************************
  logic any_elem_zero;
  logic all_elem_nonzero;
  logic vec_zero;
  logic vec_nonzero;

  // the tested vector travels on the second source port
  branch_cond_unit u_cond (
    .data_format      (data_format),
    .test_vector      (second_vector),
    .any_elem_zero    (any_elem_zero),
    .all_elem_nonzero (all_elem_nonzero),
    .vec_zero         (vec_zero),
    .vec_nonzero      (vec_nonzero)
  );

  wire logic cond_hit =
    (op == OP_BRANCH_IF_NONZERO_ELEM) ? all_elem_nonzero :
    (op == OP_BRANCH_IF_NONZERO_VEC)  ? vec_nonzero      :
    (op == OP_BRANCH_IF_ZERO_ELEM)    ? any_elem_zero    :
    (op == OP_BRANCH_IF_ZERO_VEC)     ? vec_zero         :
    1'b0;

  localparam int SEXT_W = `PC_W - `OFF_W - `WORD_SHIFT;

  wire logic [`PC_W-1:0] offset_bytes = {
    {SEXT_W{branch_offset_imm[`OFF_W-1]}},
    branch_offset_imm,
    {`WORD_SHIFT{1'b0}}
  };
  wire logic [`PC_W-1:0] target_pc = delay_slot_pc + offset_bytes;
  wire logic [`PC_W-1:0] seq_pc    = delay_slot_pc + `INSN_BYTES;

  // ****************************************************************
  // next values
  // ****************************************************************
  wire logic              nxt_wr_en      = is_write;
  wire logic [`VEC_W-1:0] nxt_result     = is_write ? op_result : result_ff;
  wire logic              nxt_br_valid   = is_branch;
  wire logic              nxt_br_taken   = is_branch && cond_hit;
  wire logic [`PC_W-1:0]  nxt_br_target  =
    is_branch ? target_pc : branch_target_ff;
  wire logic [`PC_W-1:0]  nxt_next_pc    =
    !is_branch ? next_pc_ff : (cond_hit ? target_pc : seq_pc);
  // the slot never gets squashed, whatever the outcome
  wire logic              nxt_slot_run   = is_branch;
  // no operation of this group has a data-dependent trap
  wire logic              nxt_data_exc   = 1'b0;

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_en_ff  <= 1'b0;
      result_ff <= '0;
    end else begin
      wr_en_ff  <= nxt_wr_en;
      result_ff <= nxt_result;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      branch_valid_ff   <= 1'b0;
      branch_taken_ff   <= 1'b0;
      branch_target_ff  <= `PC_RESET;
      next_pc_ff        <= `PC_RESET;
      delay_slot_run_ff <= 1'b0;
      data_exc_ff       <= 1'b0;
    end else begin
      branch_valid_ff   <= nxt_br_valid;
      branch_taken_ff   <= nxt_br_taken;
      branch_target_ff  <= nxt_br_target;
      next_pc_ff        <= nxt_next_pc;
      delay_slot_run_ff <= nxt_slot_run;
      data_exc_ff       <= nxt_data_exc;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence branch_issue_s;
    issue_valid && is_branch_op(op);
  endsequence

  sequence branch_done_s;
    branch_valid_ff && delay_slot_run_ff;
  endsequence

  slot_always_runs_a: assert property (
    branch_issue_s |=> branch_done_s ##1 (!delay_slot_run_ff or branch_done_s)
  ) else $error("delay slot not executed after vector branch");

  target_word_offset_a: assert property (
    branch_issue_s |=> branch_target_ff ==
      $past(delay_slot_pc) + {{SEXT_W{$past(branch_offset_imm[`OFF_W-1])}},
        $past(branch_offset_imm), {`WORD_SHIFT{1'b0}}}
  ) else $error("branch target differs from slot pc plus word offset");

  elem_nonzero_taken_a: assert property (
    issue_valid && op == OP_BRANCH_IF_NONZERO_ELEM && ~|second_vector
      |=> branch_valid_ff && !branch_taken_ff
  ) else $error("element non-zero branch taken on a zero vector");

  vec_nonzero_taken_a: assert property (
    issue_valid && op == OP_BRANCH_IF_NONZERO_VEC
      |=> branch_taken_ff == |$past(second_vector)
  ) else $error("whole-vector non-zero branch outcome wrong");

  elem_zero_taken_a: assert property (
    issue_valid && op == OP_BRANCH_IF_ZERO_ELEM &&
      second_vector[63:0] == 64'h0 |=> branch_taken_ff
  ) else $error("element zero branch not taken with a zero element");

  vec_zero_taken_a: assert property (
    issue_valid && op == OP_BRANCH_IF_ZERO_VEC
      |=> branch_taken_ff == ~|$past(second_vector)
  ) else $error("whole-vector zero branch outcome wrong");

  reg_select_a: assert property (
    issue_valid && op == OP_VECTOR_BIT_SELECT |=> wr_en_ff &&
      result_ff == (($past(source_vector) & ~$past(dest_vector)) |
                    ($past(second_vector) & $past(dest_vector)))
  ) else $error("register bit select result wrong");

  imm_select_a: assert property (
    issue_valid && op == OP_IMMEDIATE_BIT_SELECT && dest_vector[7:0] == 8'hFF
      |=> result_ff[7:0] == $past(byte_immediate)
  ) else $error("immediate bit select ignores immediate under full mask");

  force_keeps_src_a: assert property (
    issue_valid && op == OP_VECTOR_BIT_FORCE_ONE && data_format == FMT_BYTE
      |=> (result_ff & $past(source_vector)) == $past(source_vector) &&
          result_ff[$past(second_vector[2:0])] == 1'b1
  ) else $error("register force-one lost bits or missed position");

  imm_force_bit_a: assert property (
    issue_valid && op == OP_IMMEDIATE_BIT_FORCE_ONE &&
      data_format == FMT_DOUBLE |=> result_ff[$past(bit_index_imm)]
  ) else $error("immediate force-one did not set indexed bit");

  equal_mask_a: assert property (
    issue_valid && op == OP_VECTOR_EQUAL_COMPARE && data_format == FMT_WORD
      |=> result_ff[31:0] ==
          {32{$past(source_vector[31:0]) == $past(second_vector[31:0])}}
  ) else $error("equality compare lane mask wrong");

  no_data_trap_a: assert property (
    !data_exc_ff
  ) else $error("data-dependent exception raised");

  untaken_sequential_a: assert property (
    branch_issue_s ##1 !branch_taken_ff |->
      next_pc_ff == $past(delay_slot_pc) + `INSN_BYTES && !wr_en_ff &&
      result_ff == $past(result_ff)
  ) else $error("untaken branch changed more than the pc");

  sequence branch_taken_s;
    branch_valid_ff && branch_taken_ff;
  endsequence

  taken_goes_target_a: assert property (
    branch_issue_s ##1 branch_taken_s |-> next_pc_ff == branch_target_ff
  ) else $error("taken branch did not resume at its target");

  branch_no_write_a: assert property (
    branch_issue_s |=> !wr_en_ff && result_ff == $past(result_ff)
  ) else $error("vector branch changed the result register");

  idle_holds_result_a: assert property (
    !(issue_valid && is_write_op(op)) |=> !wr_en_ff &&
      result_ff == $past(result_ff)
  ) else $error("result changed without a write operation");

  pc_only_on_branch_a: assert property (
    !(issue_valid && is_branch_op(op)) |=> next_pc_ff == $past(next_pc_ff) &&
      branch_target_ff == $past(branch_target_ff) && !branch_valid_ff
  ) else $error("pc outputs moved without a vector branch");

  write_pulse_a: assert property (
    issue_valid && is_write_op(op) |=> wr_en_ff && !branch_valid_ff
  ) else $error("write operation gave no single write pulse");

  elem_nonzero_dbl_a: assert property (
    issue_valid && op == OP_BRANCH_IF_NONZERO_ELEM &&
      data_format == FMT_DOUBLE |=> branch_taken_ff ==
      ($past(second_vector[63:0]) != 64'h0 &&
       $past(second_vector[127:64]) != 64'h0)
  ) else $error("element non-zero branch wrong on doublewords");

  elem_zero_dbl_a: assert property (
    issue_valid && op == OP_BRANCH_IF_ZERO_ELEM &&
      data_format == FMT_DOUBLE |=> branch_taken_ff ==
      ($past(second_vector[63:0]) == 64'h0 ||
       $past(second_vector[127:64]) == 64'h0)
  ) else $error("element zero branch wrong on doublewords");

  imm_force_byte_a: assert property (
    issue_valid && op == OP_IMMEDIATE_BIT_FORCE_ONE &&
      data_format == FMT_BYTE |=> result_ff[$past(bit_index_imm[2:0])]
  ) else $error("immediate force-one missed the bit modulo byte width");

  equal_byte_a: assert property (
    issue_valid && op == OP_VECTOR_EQUAL_COMPARE && data_format == FMT_BYTE
      |=> result_ff[7:0] ==
          {8{$past(source_vector[7:0]) == $past(second_vector[7:0])}}
  ) else $error("byte equality compare lane mask wrong");

endmodule

// ### bench/issue_model.sv
`timescale 1ns/1ps
`include "vbb_map.svh"

// ********************************************************
// issue side of the core: one instruction per call
// ********************************************************
module issue_model
  import vbb_pkg::*;
(
  input  wire logic                clock,
  output logic                     issue_valid,
  output op_t                      op,
  output data_format_t             data_format,
  output logic      [`VEC_W-1:0]   dest_vector,
  output logic      [`VEC_W-1:0]   source_vector,
  output logic      [`VEC_W-1:0]   second_vector,
  output logic      [`IMM_W-1:0]   byte_immediate,
  output logic      [`BIDX_W-1:0]  bit_index_imm,
  output logic      [`OFF_W-1:0]   branch_offset_imm,
  output logic      [`PC_W-1:0]    delay_slot_pc
);
  logic last_branch;

  initial begin
    issue_valid = 1'h0;
    op = OP_NONE;
    data_format = FMT_BYTE;
    dest_vector = '0;
    source_vector = '0;
    second_vector = '0;
    byte_immediate = 8'h0;
    bit_index_imm = 6'h0;
    branch_offset_imm = 16'h0;
    delay_slot_pc = 32'h0;
    last_branch = 1'h0;
  end

  task automatic send(input op_t o, input data_format_t f,
      input logic [`VEC_W-1:0] d, input logic [`VEC_W-1:0] s,
      input logic [`VEC_W-1:0] t, input logic [`IMM_W-1:0] i8,
      input logic [`BIDX_W-1:0] bi, input logic [`OFF_W-1:0] off,
      input logic [`PC_W-1:0] pc);
    logic br;
    br = (o >= OP_BRANCH_IF_NONZERO_ELEM) && (o <= OP_BRANCH_IF_ZERO_VEC);
    @(posedge clock);
    // a branch never sits in the delay slot of another branch
    if (br && last_branch) begin
      issue_valid <= 1'h0;
      @(posedge clock);
    end
    issue_valid <= 1'h1;
    op <= o;
    data_format <= f;
    dest_vector <= d;
    source_vector <= s;
    second_vector <= t;
    byte_immediate <= i8;
    bit_index_imm <= bi;
    branch_offset_imm <= off;
    delay_slot_pc <= pc;
    last_branch = br;
  endtask

  // idle: operands no longer meaningful, so scramble them
  task automatic stop;
    @(posedge clock);
    issue_valid <= 1'h0;
    op <= OP_NONE;
    dest_vector <= ~dest_vector;
    source_vector <= ~source_vector;
    second_vector <= ~second_vector;
    last_branch = 1'h0;
  endtask
endmodule

// ### bench/tb_vector_bit_branch_compare.sv
`timescale 1ns/1ps
`include "vbb_map.svh"

module tb_vector_bit_branch_compare
  import vbb_pkg::*;
;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic issue_valid, wr_en_ff, branch_valid_ff, branch_taken_ff;
  logic delay_slot_run_ff, data_exc_ff;
  op_t op;
  data_format_t data_format;
  logic [`VEC_W-1:0] dest_vector, source_vector, second_vector, result_ff;
  logic [`IMM_W-1:0] byte_immediate;
  logic [`BIDX_W-1:0] bit_index_imm;
  logic [`OFF_W-1:0] branch_offset_imm;
  logic [`PC_W-1:0] delay_slot_pc, branch_target_ff, next_pc_ff;
  int miscompares = 0;
  int cmp_count = 0;
  logic [`VEC_W-1:0] last_res = '0;
  logic [`VEC_W-1:0] vd = 128'hFF00_F0F0_0F0F_AAAA_5555_0000_FFFF_12FF;
  logic [`VEC_W-1:0] vs = 128'h0123_4567_89AB_CDEF_0000_FFFF_1111_8000;
  logic [`VEC_W-1:0] vt = 128'h0123_4567_89AB_CDEF_0000_FFFE_1111_8007;

  always #5 clock = ~clock;

  issue_model issue_model_inst (.clock(clock), .issue_valid(issue_valid),
    .op(op), .data_format(data_format), .dest_vector(dest_vector),
    .source_vector(source_vector), .second_vector(second_vector),
    .byte_immediate(byte_immediate), .bit_index_imm(bit_index_imm),
    .branch_offset_imm(branch_offset_imm), .delay_slot_pc(delay_slot_pc));

  vector_bit_branch_compare vector_bit_branch_compare_inst (.clock(clock),
    .rstn(rstn), .issue_valid(issue_valid), .op(op),
    .data_format(data_format), .dest_vector(dest_vector),
    .source_vector(source_vector), .second_vector(second_vector),
    .byte_immediate(byte_immediate), .bit_index_imm(bit_index_imm),
    .branch_offset_imm(branch_offset_imm), .delay_slot_pc(delay_slot_pc),
    .wr_en_ff(wr_en_ff), .result_ff(result_ff),
    .branch_valid_ff(branch_valid_ff), .branch_taken_ff(branch_taken_ff),
    .branch_target_ff(branch_target_ff), .next_pc_ff(next_pc_ff),
    .delay_slot_run_ff(delay_slot_run_ff), .data_exc_ff(data_exc_ff));

  // ********************************************************
  // reference behaviour
  // ********************************************************
  function automatic logic [127:0] wexp(input op_t o, input int f,
      input logic [127:0] d, input logic [127:0] s, input logic [127:0] t,
      input logic [7:0] i8, input logic [5:0] bi);
    int w;
    logic [127:0] mk, se, te, r;
    w = 8 << f;
    mk = {128{1'h1}} >> (128 - w);
    r = '0;
    if (o == OP_VECTOR_BIT_SELECT) return (s & ~d) | (t & d);
    if (o == OP_IMMEDIATE_BIT_SELECT) return (s & ~d) | ({16{i8}} & d);
    for (int e = 0; e < 128 / w; e++) begin
      se = (s >> (e * w)) & mk;
      te = (t >> (e * w)) & mk;
      case (o)
        OP_VECTOR_BIT_FORCE_ONE: se = se | (128'h1 << (te % w));
        OP_IMMEDIATE_BIT_FORCE_ONE: se = se | (128'h1 << (bi % w));
        default: se = (se == te) ? mk : 128'h0;
      endcase
      r = r | (se << (e * w));
    end
    return r;
  endfunction

  function automatic logic bexp(input op_t o, input int f,
      input logic [127:0] v);
    int w;
    logic [127:0] mk;
    logic anyz;
    w = 8 << f;
    mk = {128{1'h1}} >> (128 - w);
    anyz = 1'h0;
    for (int e = 0; e < 128 / w; e++)
      anyz |= (((v >> (e * w)) & mk) == 128'h0);
    case (o)
      OP_BRANCH_IF_NONZERO_ELEM: return !anyz;
      OP_BRANCH_IF_NONZERO_VEC: return |v;
      OP_BRANCH_IF_ZERO_ELEM: return anyz;
      default: return ~|v;
    endcase
  endfunction

  // ********************************************************
  // comparison helpers
  // ********************************************************
  task automatic chk(input string nm, input logic [127:0] seen,
      input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk_wr(input logic [127:0] e);
    chk("wr_en", wr_en_ff, 128'h1);
    chk("result", result_ff, e);
    chk("br_valid", branch_valid_ff, 128'h0);
    chk("slot_idle", delay_slot_run_ff, 128'h0);
    chk("exc", data_exc_ff, 128'h0);
  endtask

  task automatic chk_br(input logic tk, input logic [31:0] tg,
      input logic [31:0] pc);
    chk("br_valid", branch_valid_ff, 128'h1);
    chk("slot_run", delay_slot_run_ff, 128'h1);
    chk("taken", branch_taken_ff, tk);
    chk("target", branch_target_ff, tg);
    chk("next_pc", next_pc_ff, tk ? tg : pc + 32'h4);
    chk("result_kept", result_ff, last_res);
    chk("wr_en", wr_en_ff, 128'h0);
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset;
    chk("rst_result", result_ff, 128'h0);
    chk("rst_pc", next_pc_ff, 128'h0);
    chk("rst_pulse", {wr_en_ff, branch_valid_ff}, 128'h0);
  endtask

  task automatic t_write_ops;
    logic [127:0] e;
    for (int f = 0; f < 4; f++)
      for (int k = 5; k <= 9; k++) begin
        e = wexp(op_t'(k), f, vd, vs, vt, 8'h5A, 6'h2B);
        issue_model_inst.send(op_t'(k), data_format_t'(f), vd, vs, vt,
          8'h5A, 6'h2B, 16'h0, 32'h0);
        issue_model_inst.stop();
        #1;
        chk_wr(e);
        last_res = e;
      end
  endtask

  task automatic t_branches;
    logic [127:0] v [5];
    logic [15:0] off;
    logic [31:0] tg;
    v = '{128'h0, {128{1'h1}}, 128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_00FF,
      128'h1, 128'h1_0000_0000_0000_0001};
    for (int k = 1; k <= 4; k++)
      for (int f = 0; f < 4; f++)
        for (int i = 0; i < 5; i++) begin
          off = (i % 2 == 1) ? 16'h8003 : 16'h0010;
          tg = 32'h1000 + {{14{off[15]}}, off, 2'h0};
          issue_model_inst.send(op_t'(k), data_format_t'(f), vd, vs, v[i],
            8'h0, 6'h0, off, 32'h1000);
          issue_model_inst.stop();
          #1;
          chk_br(bexp(op_t'(k), f, v[i]), tg, 32'h1000);
        end
  endtask

  task automatic t_back_to_back;
    last_res = wexp(OP_VECTOR_EQUAL_COMPARE, 0, vd, vs, vt, 8'h0, 6'h0);
    issue_model_inst.send(OP_VECTOR_EQUAL_COMPARE, FMT_BYTE, vd, vs, vt,
      8'h0, 6'h0, 16'h0, 32'h0);
    issue_model_inst.send(OP_BRANCH_IF_ZERO_VEC, FMT_WORD, vd, vs, '0,
      8'h0, 6'h0, 16'hFFFF, 32'h2000);
    #1;
    chk_wr(last_res);
    issue_model_inst.send(OP_NONE, FMT_BYTE, vd, vs, vt, 8'h0, 6'h0,
      16'h0, 32'h0);
    #1;
    chk_br(1'h1, 32'h1FFC, 32'h2000);
    issue_model_inst.stop();
    #1;
    chk("none_pulse", {wr_en_ff, branch_valid_ff, delay_slot_run_ff,
      branch_taken_ff}, 128'h0);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #500000;
    miscompares++;
    tally_and_finish;
  end

  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'h1;
    #1;
    t_reset;
    @(posedge clock);
    t_write_ops;
    t_branches;
    t_back_to_back;
    tally_and_finish;
  end
endmodule
